/* hw/adcrf_defs.vh */
`ifndef ADCRF_DEFS_VH
`define ADCRF_DEFS_VH

// Register addresses (plain port, byte address)
`define ADCRF_ADDR_W      4
`define ADCRF_OFF_CTRL    4'h0
`define ADCRF_OFF_CFG     4'h1
`define ADCRF_OFF_RESH    4'h2
`define ADCRF_OFF_RESL    4'h3
`define ADCRF_OFF_FLAG    4'h4

// Control register fields
`define ADCRF_CTRL_EN     0
`define ADCRF_CTRL_GO     1
`define ADCRF_CTRL_CHS_LO 2
`define ADCRF_CTRL_CHS_HI 6
`define ADCRF_CTRL_RST    8'h00

// Config register fields
`define ADCRF_CFG_JUST    7
`define ADCRF_CFG_MASK    8'hF3
`define ADCRF_CFG_RST     8'h00

// Flag register: completion flag in bit 0, write one to clear
`define ADCRF_FLAG_DONE   0

// Conversion: 10-bit code, one bit resolved per step
`define ADCRF_CODE_W      10
`define ADCRF_STEP_NS     100
`define ADCRF_CLK_NS      10
`define ADCRF_STEP_CYC    ((`ADCRF_STEP_NS + `ADCRF_CLK_NS - 1) / `ADCRF_CLK_NS)
`define ADCRF_CNT_W       8

`endif

/* hw/adcrf_top.v */
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "adcrf_defs.vh"

module adcrf_top (
  input  wire       clk,
  input  wire       rst,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       cmp_in,
  output reg        sample_hold,
  output reg  [9:0] dac_code,
  output reg  [4:0] channel_select,
  output reg        converter_enable
);

  // One-hot states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;
  // Marks that no bit has been resolved yet
  localparam [3:0] LAST_NONE = 4'hF;

  reg  [1:0]                 state_q;
  reg  [7:0]                 ctrl_q;
  reg  [7:0]                 cfg_q;
  reg  [7:0]                 result_high_reg;
  reg  [7:0]                 result_low_reg;
  reg                        completion_irq_flag;
  reg  [`ADCRF_CODE_W-1:0]   sar_q;
  reg  [3:0]                 bit_q;
  reg  [`ADCRF_CNT_W-1:0]    cnt_q;
  reg  [3:0]                 last_q;

  // Strobe qualified by one register address
  function hit;
    input       strobe;
    input [3:0] a;
    input [3:0] want;
    begin
      hit = strobe && (a == want);
    end
  endfunction

  wire wr_ctrl = hit(wr, addr, `ADCRF_OFF_CTRL);
  wire wr_cfg  = hit(wr, addr, `ADCRF_OFF_CFG);
  wire wr_resh = hit(wr, addr, `ADCRF_OFF_RESH);
  wire wr_resl = hit(wr, addr, `ADCRF_OFF_RESL);
  wire wr_flag = hit(wr, addr, `ADCRF_OFF_FLAG);
  wire go_q    = ctrl_q[`ADCRF_CTRL_GO];
  // Comparator only matters on the last cycle of a step
  wire step    = (state_q == ST_CONV) && (cnt_q == `ADCRF_STEP_CYC - 1);
  wire done    = step && (bit_q == 4'h0);
  wire abort   = (state_q == ST_CONV) && wr_ctrl && !wdata[`ADCRF_CTRL_GO];
  // Reset ends a conversion but never touches the results
  wire ld      = (done || abort) && !rst;
  // High means the trial bit stays
  wire res_bit = cmp_in;

  // Unresolved bits copy the last resolved one
  // partial result fill
  function [9:0] fill_code;
    input [9:0] code;
    input [3:0] last;
    integer i;
    begin
      fill_code = code;
      for (i = 0; i < 10; i = i + 1) begin
        if (i < last) begin
          fill_code[i] = code[last];
        end
      end
    end
  endfunction

  wire [9:0] code_done  = {sar_q[9:1], res_bit};
  wire [9:0] code_part  = (last_q == LAST_NONE) ? 10'h000 : fill_code(sar_q, last_q);
  wire [9:0] final_code = done ? code_done : code_part;

  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      ctrl_q  <= `ADCRF_CTRL_RST;
      cfg_q   <= `ADCRF_CFG_RST;
      sar_q   <= 10'h000;
      bit_q   <= 4'h9;
      cnt_q   <= {`ADCRF_CNT_W{1'b0}};
      last_q  <= 4'hF;
    end else begin
      if (wr_cfg) begin
        cfg_q <= wdata & `ADCRF_CFG_MASK;
      end
      if (wr_ctrl) begin
        ctrl_q <= {1'b0, wdata[6:0]};
      end
      case (state_q)
        ST_IDLE: begin
          // Enable must be stored first; go in the enabling write is ignored
          if (wr_ctrl && wdata[`ADCRF_CTRL_GO] && ctrl_q[`ADCRF_CTRL_EN] &&
              wdata[`ADCRF_CTRL_EN]) begin
            state_q <= ST_CONV;
            sar_q   <= 10'h200;
            bit_q   <= 4'h9;
            cnt_q   <= {`ADCRF_CNT_W{1'b0}};
            last_q  <= 4'hF;
          end else if (wr_ctrl) begin
            ctrl_q[`ADCRF_CTRL_GO] <= 1'b0;
          end
        end
        ST_CONV: begin
          // Dropping enable abandons the run; the results are left alone only if go stays set in that write, else the abort loads the partial code
          if (abort || !ctrl_q[`ADCRF_CTRL_EN]) begin
            state_q <= ST_IDLE;
            ctrl_q[`ADCRF_CTRL_GO] <= 1'b0;
          end else if (step) begin
            cnt_q  <= {`ADCRF_CNT_W{1'b0}};
            last_q <= bit_q;
            // Keep or drop the trial bit on the comparator
            sar_q[bit_q] <= res_bit;
            if (bit_q == 4'h0) begin
              state_q <= ST_IDLE;
              ctrl_q[`ADCRF_CTRL_GO] <= 1'b0;
            end else begin
              // one trial bit per step, 10 steps
              sar_q[bit_q - 4'h1] <= 1'b1;
              bit_q <= bit_q - 4'h1;
            end
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // results not reset; writable by software
  always @(posedge clk) begin
    if (ld) begin
      if (cfg_q[`ADCRF_CFG_JUST]) begin
        // upper two bits low in high register
        result_high_reg <= {6'h00, final_code[9:8]};
        result_low_reg  <= final_code[7:0];
      end else begin
        result_high_reg <= final_code[9:2];
        result_low_reg  <= {final_code[1:0], 6'h00};
      end
    end else if (wr_resh) begin
      // Software write, only when no load is due
      result_high_reg <= wdata;
    end else if (wr_resl) begin
      result_low_reg <= wdata;
    end
  end

  // completion flag, set wins over clear
  always @(posedge clk) begin
    if (rst) begin
      completion_irq_flag <= 1'b0;
    end else if (done) begin
      completion_irq_flag <= 1'b1;
    end else if (wr_flag && wdata[`ADCRF_FLAG_DONE]) begin
      completion_irq_flag <= 1'b0;
    end
  end

  // Status outputs lag the internal state by one cycle
  always @(posedge clk) begin
    if (rst) begin
      rdata            <= 8'h00;
      sample_hold      <= 1'b0;
      dac_code         <= 10'h000;
      channel_select   <= 5'h00;
      converter_enable <= 1'b0;
    end else begin
      sample_hold      <= (state_q == ST_CONV);
      dac_code         <= sar_q;
      channel_select   <= ctrl_q[`ADCRF_CTRL_CHS_HI:`ADCRF_CTRL_CHS_LO];
      converter_enable <= ctrl_q[`ADCRF_CTRL_EN];
      // Idle slots and unmapped addresses read zero
      rdata            <= 8'h00;
      if (rd) begin
        if (addr == `ADCRF_OFF_CTRL) begin
          rdata <= {1'b0, ctrl_q[6:2], go_q, ctrl_q[0]};
        end else if (addr == `ADCRF_OFF_CFG) begin
          rdata <= cfg_q;
        end else if (addr == `ADCRF_OFF_RESH) begin
          rdata <= result_high_reg;
        end else if (addr == `ADCRF_OFF_RESL) begin
          rdata <= result_low_reg;
        end else if (addr == `ADCRF_OFF_FLAG) begin
          rdata <= {7'h00, completion_irq_flag};
        end
      end
    end
  end

endmodule

/* test/adcrf_chk_assertions.sv */
`timescale 1ns/1ps
module adcrf_chk (
  input logic       clk,
  input logic       rst,
  input logic [3:0] addr,
  input logic [7:0] wdata,
  input logic       wr,
  input logic       rd,
  input logic [7:0] rdata,
  input logic       cmp_in,
  input logic       sample_hold,
  input logic [9:0] dac_code,
  input logic [4:0] channel_select,
  input logic       converter_enable
);
  logic just_now_q, just_q, clean_q;
  // Software writes to results void the zero-bit checks until sample_hold next falls
  // Justify is taken as it stood in config at the load edge
  always_ff @(posedge clk) begin
    if (wr && addr == 4'h1)
      just_now_q <= wdata[7];
    if (rst || (wr && addr[3:1] == 3'h1))
      clean_q <= 1'b0;
    else if ($fell(sample_hold)) begin
      clean_q <= 1'b1;
      just_q  <= $past(just_now_q, 2);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  go_start_a: assert property (wr && addr == 4'h0 && wdata[1:0] == 2'h3 && converter_enable
    && !sample_hold && !$past(wr && addr == 4'h0 && !wdata[0]) |-> ##[1:2] sample_hold)
    else $error("go not started");
  go_gated_a: assert property ($rose(sample_hold) |-> converter_enable)
    else $error("start while disabled");
  conv_min_a: assert property ($rose(sample_hold) |-> sample_hold[*8])
    else $error("conversion too short");
  conv_end_a: assert property (sample_hold |-> ##[0:105] !sample_hold)
    else $error("conversion never ends");
  stop_off_a: assert property (!converter_enable |-> ##[0:2] !sample_hold)
    else $error("converting while off");
  enable_copy_a: assert property (wr && addr == 4'h0 |-> ##2 converter_enable ==
    $past(wdata[0], 2)) else $error("enable not taken");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside slot");
  low_zero_a: assert property (rd && addr == 4'h3 && clean_q && !just_q |=>
    rdata[5:0] == 6'h00) else $error("low unused bits set");
  high_zero_a: assert property (rd && addr == 4'h2 && clean_q && just_q |=>
    rdata[7:2] == 6'h00) else $error("high unused bits set");
endmodule
bind adcrf_top adcrf_chk u_chk (.*);

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, cmp_in = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [9:0] tgt = 10'h000;
  wire  [7:0] rdata;
  wire  [9:0] dac_code;
  wire  [4:0] channel_select;
  wire        sample_hold, converter_enable;
  int         fail_count = 0, samples_checked = 0;
  // Acquisition wait of 4.42 us at 10 ns per cycle
  localparam int ACQ_CYC = 442;
  adcrf_top u_dut (
    .clk              (clk),
    .rst              (rst),
    .addr             (addr),
    .wdata            (wdata),
    .wr               (wr),
    .rd               (rd),
    .rdata            (rdata),
    .cmp_in           (cmp_in),
    .sample_hold      (sample_hold),
    .dac_code         (dac_code),
    .channel_select   (channel_select),
    .converter_enable (converter_enable)
  );
  always #5 clk = ~clk;
  // Comparator: keep the trial bit while trial code is at or below target
  always @(posedge clk) cmp_in <= (dac_code <= tgt);
  task automatic chk(input logic [9:0] got, input logic [9:0] want);
    samples_checked++;
    if (got !== want) begin
      fail_count++;
      $display("mismatch %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
    if (!w) chk(rdata, d);
  endtask
  // Abort write after ab cycles only when ab is below 100; jl is justify at load
  task automatic run(input logic j, input logic jl, input logic [9:0] t, input int ab,
                     input logic [9:0] e);
    tgt = t;
    bus(1, 4'h1, {j, 7'h00});
    bus(1, 4'h0, 8'h01);
    repeat (ACQ_CYC) @(posedge clk);
    bus(1, 4'h0, 8'h03);
    bus(0, 4'h0, 8'h03);
    chk(dac_code, 10'h200);
    chk(sample_hold, 1'b1);
    bus(1, 4'h1, {jl, 7'h00});
    repeat (ab) @(posedge clk);
    if (ab < 100) bus(1, 4'h0, 8'h01);
    bus(0, 4'h0, 8'h01);
    bus(0, 4'h4, {7'h00, ab > 100});
    bus(0, 4'h2, jl ? {6'h00, e[9:8]} : e[9:2]);
    bus(0, 4'h3, jl ? e[7:0] : {e[1:0], 6'h00});
    bus(1, 4'h4, 8'h01);
  endtask
  task automatic conclude;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    bus(1, 4'h0, 8'h02);
    bus(0, 4'h0, 8'h00);
    bus(1, 4'h1, 8'hFF);
    bus(0, 4'h1, 8'hF3);
    bus(0, 4'hF, 8'h00);
    bus(1, 4'h0, 8'h7D);
    @(posedge clk);
    #1;
    chk(channel_select, 5'h1F);
    chk(converter_enable, 1'b1);
    run(0, 0, 10'h2B5, 110, 10'h2B5);
    run(1, 1, 10'h16A, 110, 10'h16A);
    run(1, 1, 10'h3FF, 110, 10'h3FF);
    run(0, 0, 10'h000, 110, 10'h000);
    run(1, 1, 10'h3C0, 40, 10'h3FF);
    run(0, 0, 10'h23F, 40, 10'h200);
    bus(1, 4'h2, 8'h5A);
    bus(0, 4'h2, 8'h5A);
    run(0, 1, 10'h16A, 110, 10'h16A);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    bus(0, 4'h0, 8'h00);
    bus(0, 4'h2, 8'h01);
    bus(0, 4'h3, 8'h6A);
    conclude;
  end
  initial begin
    #200000;
    fail_count++;
    $display("mismatch %0t watchdog expired", $time);
    conclude;
  end
endmodule
